// *** hdl/adc_seq_pkg.sv ***
// Constants and types for the converter sequencer and result transfer engine.
// Assumes one 25 MHz core clock and an APB master with 8-bit byte addresses.
package adc_seq_pkg;
    // Register byte offsets
    localparam logic [7:0]  CTRL0_OFS      = 8'h00;
    localparam logic [7:0]  CTRL1_OFS      = 8'h04;
    localparam logic [7:0]  RESULT_OFS     = 8'h08;
    localparam logic [7:0]  XCTRL_OFS      = 8'h0c;
    localparam logic [7:0]  XCOUNT_OFS     = 8'h10;
    localparam logic [7:0]  XSTART_OFS     = 8'h14;
    // Control register 0 fields
    localparam int          START_BIT      = 0;
    localparam int          ENABLE_BIT     = 1;
    localparam int          FLAG_BIT       = 2;
    localparam int          IE_BIT         = 3;
    localparam int          AUTO_BIT       = 7;
    // Control register 1 fields
    localparam int          MODE_LSB       = 0;
    localparam int          BUSY_BIT       = 2;
    localparam int          CHAN_LSB       = 12;
    // Transfer control fields
    localparam int          B1_BIT         = 0;
    localparam int          CONT_BIT       = 1;
    localparam int          TWOB_BIT       = 2;
    // Values after reset
    localparam logic [15:0] START_ADDR_RST = 16'h0200;
    // Sequence modes and temperature channel
    localparam logic [1:0]  MODE_SINGLE    = 2'h0;
    localparam logic [1:0]  MODE_SEQ       = 2'h1;
    localparam logic [1:0]  MODE_REP       = 2'h2;
    localparam logic [1:0]  MODE_REPSEQ    = 2'h3;
    localparam logic [3:0]  TEMP_CHANNEL   = 4'ha;
    // Timing
    localparam logic [3:0]  SAMPLE_LAST    = 4'h3;
    localparam logic [3:0]  CONVERT_LAST   = 4'hc;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          WAKE_TIME_NS   = 6000;
    localparam int          WAKE_CYCLES    = (WAKE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : WAKE_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0]  WAKE_LAST      = 8'(WAKE_CYCLES - 1);

    typedef enum logic [1:0] {CV_IDLE, CV_SAMPLE, CV_CONVERT} conv_state_type;
    typedef enum logic [1:0] {XF_IDLE, XF_WAKE, XF_SYNC, XF_MOVE} xfer_state_type;
endpackage

// *** hdl/adc_sequencer_result_transfer.sv ***
// Sequencer for a 10-bit converter with an embedded result transfer engine.
// Assumes an APB master, an analog core that returns convResult at conversion end,
// and a memory bus that accepts a one-cycle write while the processor is halted.
module adc_sequencer_result_transfer (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog core
    input  wire logic        sampleTriggerInput,
    input  wire logic [9:0]  convResult,
    output logic             samplingOn,
    output logic             convertingOn,
    output logic      [3:0]  activeChannel,
    output logic             tempRefOn,
    // Memory bus and clock system
    input  wire logic        mainClkStopped,
    output logic             memWrite,
    output logic      [15:0] memAddr,
    output logic      [15:0] memWdata,
    output logic             cpuHalt,
    output logic             mainClkRun,
    // Interrupt
    input  wire logic        globalIrqEnable,
    input  wire logic        irqAck,
    output logic             irqRequest
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    adc_seq_pkg::conv_state_type cState_r;
    adc_seq_pkg::xfer_state_type xState_r;
    logic        enable_r;
    logic        autoRep_r;
    logic        ie_r;
    logic        flag_r;
    logic [1:0]  mode_r;
    logic [3:0]  chanSel_r;
    logic [9:0]  result_r;
    logic [7:0]  xCount_r;
    logic [15:0] startAddr_r;
    logic        twoBlock_r;
    logic        cont_r;
    logic [3:0]  cycCnt_r;
    logic [3:0]  curChan_r;
    logic        seqActive_r;
    logic        lockout_r;
    logic        resultLoad_r;
    logic        swStart_r;
    logic        trigSync1_r;
    logic        trigSync2_r;
    logic        trigSync3_r;
    logic        trigLevel_r;
    logic        trigRise_r;
    logic [15:0] xPtr_r;
    logic [7:0]  xCnt_r;
    logic        b1Full_r;
    logic        xStopped_r;
    logic [7:0]  wakeCnt_r;
    logic [31:0] rdMux;
    logic        wrCycle;
    logic        mapped;
    logic        startReq;
    logic        trigOk;
    logic        abortNow;
    logic        convDone;
    logic        seqMore;
    logic        autoNext;
    logic        xEnabled;
    logic        blockDone;
    logic        flagSet;

    // APB decode; every access completes without wait states
    assign wrCycle = psel && penable && pwrite;
    assign mapped  = (paddr == adc_seq_pkg::CTRL0_OFS) || (paddr == adc_seq_pkg::CTRL1_OFS)
                  || (paddr == adc_seq_pkg::RESULT_OFS) || (paddr == adc_seq_pkg::XCTRL_OFS)
                  || (paddr == adc_seq_pkg::XCOUNT_OFS) || (paddr == adc_seq_pkg::XSTART_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            adc_seq_pkg::CTRL0_OFS:
            begin
                rdMux[adc_seq_pkg::ENABLE_BIT] = enable_r;
                rdMux[adc_seq_pkg::FLAG_BIT]   = flag_r;
                rdMux[adc_seq_pkg::IE_BIT]     = ie_r;
                rdMux[adc_seq_pkg::AUTO_BIT]   = autoRep_r;
            end
            adc_seq_pkg::CTRL1_OFS:
            begin
                rdMux[adc_seq_pkg::MODE_LSB +: 2] = mode_r;
                rdMux[adc_seq_pkg::BUSY_BIT]      = (cState_r != adc_seq_pkg::CV_IDLE) || seqActive_r;
                rdMux[adc_seq_pkg::CHAN_LSB +: 4] = chanSel_r;
            end
            adc_seq_pkg::RESULT_OFS: rdMux[9:0] = result_r;
            adc_seq_pkg::XCTRL_OFS:
            begin
                rdMux[adc_seq_pkg::B1_BIT]   = b1Full_r;
                rdMux[adc_seq_pkg::CONT_BIT] = cont_r;
                rdMux[adc_seq_pkg::TWOB_BIT] = twoBlock_r;
            end
            adc_seq_pkg::XCOUNT_OFS: rdMux[7:0]  = xCount_r;
            adc_seq_pkg::XSTART_OFS: rdMux[15:0] = startAddr_r;
            default:                 rdMux      = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup phase, stable through the access phase
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
            prdata <= rdMux;

    // Software registers; channel and mode only change while disabled
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            enable_r    <= 1'b0;
            autoRep_r   <= 1'b0;
            ie_r        <= 1'b0;
            mode_r      <= adc_seq_pkg::MODE_SINGLE;
            chanSel_r   <= 4'h0;
            xCount_r    <= 8'h00;
            startAddr_r <= adc_seq_pkg::START_ADDR_RST;
            twoBlock_r  <= 1'b0;
            cont_r      <= 1'b0;
            swStart_r   <= 1'b0;
        end
        else
        begin
            swStart_r <= wrCycle && (paddr == adc_seq_pkg::CTRL0_OFS) && pwdata[adc_seq_pkg::START_BIT];
            if (wrCycle && paddr == adc_seq_pkg::CTRL0_OFS)
            begin
                enable_r  <= pwdata[adc_seq_pkg::ENABLE_BIT];
                ie_r      <= pwdata[adc_seq_pkg::IE_BIT];
                autoRep_r <= pwdata[adc_seq_pkg::AUTO_BIT];
            end
            if (wrCycle && paddr == adc_seq_pkg::CTRL1_OFS && !enable_r)
            begin
                mode_r    <= pwdata[adc_seq_pkg::MODE_LSB +: 2];
                chanSel_r <= pwdata[adc_seq_pkg::CHAN_LSB +: 4];
            end
            if (wrCycle && paddr == adc_seq_pkg::XCTRL_OFS)
            begin
                twoBlock_r <= pwdata[adc_seq_pkg::TWOB_BIT];
                cont_r     <= pwdata[adc_seq_pkg::CONT_BIT];
            end
            if (wrCycle && paddr == adc_seq_pkg::XCOUNT_OFS)
                xCount_r <= pwdata[7:0];
            if (wrCycle && paddr == adc_seq_pkg::XSTART_OFS)
                startAddr_r <= pwdata[15:0];
        end

    // Trigger pin: a rising level change counts once the second and third stages agree
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            trigSync1_r <= 1'b0;
            trigSync2_r <= 1'b0;
            trigSync3_r <= 1'b0;
            trigLevel_r <= 1'b0;
            trigRise_r  <= 1'b0;
        end
        else
        begin
            trigSync1_r <= sampleTriggerInput;
            trigSync2_r <= trigSync1_r;
            trigSync3_r <= trigSync2_r;
            if (trigSync2_r == trigSync3_r)
                trigLevel_r <= trigSync3_r;
            trigRise_r <= (trigSync2_r == trigSync3_r) && trigSync3_r && !trigLevel_r;
        end

    assign startReq = swStart_r || trigRise_r;
    // A sequence still running after enable drops keeps taking its triggers
    assign trigOk   = startReq && !lockout_r && (cState_r == adc_seq_pkg::CV_IDLE)
                   && (enable_r || seqActive_r);
    assign abortNow = !enable_r && (mode_r == adc_seq_pkg::MODE_SINGLE);
    assign convDone = (cState_r == adc_seq_pkg::CV_CONVERT) && (cycCnt_r == 4'h0);
    assign seqMore  = mode_r[0] && (curChan_r != 4'h0);
    // Mid-sequence continues regardless of enable; repeats need enable
    assign autoNext = seqMore ? autoRep_r : (mode_r[1] && enable_r && autoRep_r);

    // Conversion sequencer
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            cState_r    <= adc_seq_pkg::CV_IDLE;
            cycCnt_r    <= 4'h0;
            curChan_r   <= 4'h0;
            seqActive_r <= 1'b0;
        end
        else if (abortNow)
        begin
            cState_r    <= adc_seq_pkg::CV_IDLE;
            seqActive_r <= 1'b0;
        end
        else
        begin
            unique case (cState_r)
                adc_seq_pkg::CV_IDLE:
                    if (trigOk)
                    begin
                        cState_r    <= adc_seq_pkg::CV_SAMPLE;
                        cycCnt_r    <= adc_seq_pkg::SAMPLE_LAST;
                        seqActive_r <= mode_r[0];
                        if (!seqActive_r)
                            curChan_r <= chanSel_r;
                    end
                adc_seq_pkg::CV_SAMPLE:
                    if (cycCnt_r == 4'h0)
                    begin
                        cState_r <= adc_seq_pkg::CV_CONVERT;
                        cycCnt_r <= adc_seq_pkg::CONVERT_LAST;
                    end
                    else
                        cycCnt_r <= cycCnt_r - 4'h1;
                adc_seq_pkg::CV_CONVERT:
                    if (cycCnt_r != 4'h0)
                        cycCnt_r <= cycCnt_r - 4'h1;
                    else
                    begin
                        cState_r    <= autoNext ? adc_seq_pkg::CV_SAMPLE : adc_seq_pkg::CV_IDLE;
                        cycCnt_r    <= adc_seq_pkg::SAMPLE_LAST;
                        curChan_r   <= seqMore ? curChan_r - 4'h1 : chanSel_r;
                        seqActive_r <= seqMore || (mode_r[0] && autoNext);
                    end
                default: cState_r <= adc_seq_pkg::CV_IDLE;
            endcase
        end

    // Auto-repeat lockout: released by the end of a single sequence or enable low
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            lockout_r <= 1'b0;
        else if (!enable_r)
            lockout_r <= 1'b0;
        else if (trigOk && autoRep_r && mode_r != adc_seq_pkg::MODE_SINGLE)
            lockout_r <= 1'b1;
        else if (convDone && mode_r == adc_seq_pkg::MODE_SEQ && !seqMore)
            lockout_r <= 1'b0;

    // Result register, loaded the edge after conversion end
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            result_r     <= 10'h000;
            resultLoad_r <= 1'b0;
        end
        else
        begin
            resultLoad_r <= convDone;
            if (convDone)
                result_r <= convResult;
        end

    assign samplingOn    = (cState_r == adc_seq_pkg::CV_SAMPLE);
    assign convertingOn  = (cState_r == adc_seq_pkg::CV_CONVERT);
    assign activeChannel = curChan_r;
    // Reference only; output pin and reference selection are untouched
    assign tempRefOn     = (chanSel_r == adc_seq_pkg::TEMP_CHANNEL);

    // Transfer engine
    assign xEnabled  = (xCount_r != 8'h00);
    assign blockDone = (xState_r == adc_seq_pkg::XF_MOVE) && (xCnt_r == 8'h01);

    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            xState_r  <= adc_seq_pkg::XF_IDLE;
            wakeCnt_r <= 8'h00;
        end
        else
        begin
            unique case (xState_r)
                adc_seq_pkg::XF_IDLE:
                    if (resultLoad_r && xEnabled && !xStopped_r)
                    begin
                        // Clock restart costs the oscillator wake time
                        xState_r  <= mainClkStopped ? adc_seq_pkg::XF_WAKE : adc_seq_pkg::XF_SYNC;
                        wakeCnt_r <= adc_seq_pkg::WAKE_LAST;
                    end
                adc_seq_pkg::XF_WAKE:
                    if (wakeCnt_r == 8'h00)
                        xState_r <= adc_seq_pkg::XF_SYNC;
                    else
                        wakeCnt_r <= wakeCnt_r - 8'h01;
                adc_seq_pkg::XF_SYNC: xState_r <= adc_seq_pkg::XF_MOVE;
                adc_seq_pkg::XF_MOVE: xState_r <= adc_seq_pkg::XF_IDLE;
            endcase
        end

    // Pointer and counter; a count or start write re-initialises the engine
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
        begin
            xPtr_r     <= adc_seq_pkg::START_ADDR_RST;
            xCnt_r     <= 8'h00;
            b1Full_r   <= 1'b0;
            xStopped_r <= 1'b0;
        end
        else if (wrCycle && paddr == adc_seq_pkg::XSTART_OFS)
        begin
            xPtr_r     <= pwdata[15:0];
            xCnt_r     <= xCount_r;
            b1Full_r   <= 1'b0;
            xStopped_r <= 1'b0;
        end
        else if (wrCycle && paddr == adc_seq_pkg::XCOUNT_OFS)
        begin
            xPtr_r     <= startAddr_r;
            xCnt_r     <= pwdata[7:0];
            b1Full_r   <= 1'b0;
            xStopped_r <= 1'b0;
        end
        else if (xState_r == adc_seq_pkg::XF_MOVE)
        begin
            xPtr_r <= xPtr_r + 16'h0002;
            xCnt_r <= xCnt_r - 8'h01;
            if (blockDone)
            begin
                if (twoBlock_r && !b1Full_r)
                begin
                    b1Full_r <= 1'b1;
                    xCnt_r   <= xCount_r;
                end
                else
                begin
                    b1Full_r <= 1'b0;
                    if (cont_r)
                    begin
                        xPtr_r <= startAddr_r;
                        xCnt_r <= xCount_r;
                    end
                    else
                        xStopped_r <= 1'b1;
                end
            end
        end

    assign memWrite   = (xState_r == adc_seq_pkg::XF_MOVE);
    assign cpuHalt    = (xState_r == adc_seq_pkg::XF_MOVE);
    assign memAddr    = xPtr_r;
    assign memWdata   = {6'h00, result_r};
    // Main clock requested only while a transfer is under way
    assign mainClkRun = (xState_r != adc_seq_pkg::XF_IDLE);

    // Flag: a set in the same cycle as a clear wins
    assign flagSet = (resultLoad_r && !xEnabled) || blockDone;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            flag_r <= 1'b0;
        else if (flagSet)
            flag_r <= 1'b1;
        else if (wrCycle && paddr == adc_seq_pkg::CTRL0_OFS)
            flag_r <= pwdata[adc_seq_pkg::FLAG_BIT];
        else if (irqAck)
            flag_r <= 1'b0;

    assign irqRequest = flag_r && ie_r && globalIrqEnable;

    AST_SINGLE_ABORT: assert property (abortNow |=> cState_r == adc_seq_pkg::CV_IDLE && !seqActive_r)
        else $error("single mode did not abort when enable cleared");
    AST_REPEAT_STOP: assert property (convDone && mode_r == adc_seq_pkg::MODE_REP && !enable_r
        |=> cState_r == adc_seq_pkg::CV_IDLE)
        else $error("repeat single mode kept converting after enable cleared");
    AST_AUTO_NEXT: assert property (convDone && autoRep_r && enable_r
        && mode_r == adc_seq_pkg::MODE_REP
        |=> cState_r == adc_seq_pkg::CV_SAMPLE ##4 cState_r == adc_seq_pkg::CV_CONVERT)
        else $error("auto-repeat did not start the next conversion");
    AST_XFER_TIME: assert property (xState_r == adc_seq_pkg::XF_IDLE && resultLoad_r
        && xEnabled && !xStopped_r && !mainClkStopped |-> ##2 memWrite ##1 !memWrite)
        else $error("transfer not made two cycles after result load");
    AST_WAKE_TIME: assert property (xState_r == adc_seq_pkg::XF_IDLE && resultLoad_r
        && xEnabled && !xStopped_r && mainClkStopped |-> ##152 memWrite)
        else $error("woken transfer not made within the wake time");
    AST_IDLE_OFF: assert property (!xEnabled && xState_r == adc_seq_pkg::XF_IDLE
        |=> xState_r == adc_seq_pkg::XF_IDLE)
        else $error("transfer engine started with zero count");
    AST_PTR_STEP: assert property (memWrite && !blockDone && !wrCycle
        |=> xPtr_r == $past(xPtr_r) + 16'h0002)
        else $error("pointer did not advance by two");
    AST_B1_SET: assert property (blockDone && twoBlock_r && !b1Full_r && !wrCycle
        |=> b1Full_r && flag_r && xCnt_r == xCount_r)
        else $error("first block completion not flagged");
    AST_B2_CLR: assert property (blockDone && b1Full_r && !wrCycle |=> !b1Full_r && flag_r)
        else $error("second block completion not flagged");
    AST_LOAD_FLAG: assert property (resultLoad_r && !xEnabled |=> flag_r)
        else $error("flag not set on result load");
    AST_WAKE: assert property ($rose(mainClkRun) |-> $past(resultLoad_r))
        else $error("main clock requested without a result load");

    COV_TWO_BLOCK: cover property (blockDone && b1Full_r);
    COV_WRAP: cover property (blockDone && cont_r);
    COV_SEQ_END: cover property (convDone && mode_r == adc_seq_pkg::MODE_SEQ && !seqMore);
    COV_WAKE: cover property (xState_r == adc_seq_pkg::XF_WAKE ##1 xState_r == adc_seq_pkg::XF_WAKE);
endmodule

// *** test/adc_far_side_model.sv ***
// Far-side model: analog core and memory bus.
// Assumes activeChannel names the channel under conversion.
module adc_far_side_model (
    // Analog core
    input  wire logic        core_clk,
    input  wire logic [3:0]  activeChannel,
    output logic      [9:0]  convResult,
    // Memory bus and clock system
    input  wire logic        memWrite,
    input  wire logic        cpuHalt,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWdata,
    output logic             mainClkStopped
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] addrLog[$];
    logic [15:0] dataLog[$];
    logic        clkOff = 1'b0;
    // Main clock off only while the bench asks, to reach the wake path
    assign mainClkStopped = clkOff;
    // Channel in result so order shows
    assign convResult = {6'h2a, activeChannel};
    always @(posedge core_clk)
        if (memWrite === 1'b1 && cpuHalt === 1'b1)
        begin
            addrLog.push_back(memAddr);
            dataLog.push_back(memWdata);
        end
endmodule

// *** test/adc_sequencer_result_transfer_bench.sv ***
// Bench: APB sequences against expected values.
// Assumes the far-side model logs every memory write.
`define CHECK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h, expected %h", $time, a, e); end end
module adc_sequencer_result_transfer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, trig = 0, global_irq_enable = 1, ack = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, samp, conv, tref, mw, halt, mrun, irq, stopped;
    logic [3:0] chan;
    logic [9:0] res;
    logic [15:0] ma, md;
    int n_errors = 0, num_checks = 0;
    adc_sequencer_result_transfer uut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sampleTriggerInput(trig), .convResult(res),
        .samplingOn(samp), .convertingOn(conv), .activeChannel(chan), .tempRefOn(tref),
        .mainClkStopped(stopped), .memWrite(mw), .memAddr(ma), .memWdata(md), .cpuHalt(halt),
        .mainClkRun(mrun), .globalIrqEnable(global_irq_enable), .irqAck(ack), .irqRequest(irq));
    adc_far_side_model far (.core_clk(core_clk), .activeChannel(chan), .convResult(res),
        .memWrite(mw), .cpuHalt(halt), .memAddr(ma), .memWdata(md), .mainClkStopped(stopped));
    always #20 core_clk = ~core_clk;
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitXfer(input int n);
        repeat (3000) if (far.addrLog.size() < n) @(posedge core_clk);
        `CHECK(far.addrLog.size(), n)
    endtask
    task automatic results;
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        results();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(0, adc_seq_pkg::XSTART_OFS, 0);
        `CHECK(q, 32'h0000_0200)
        apb(0, 8'h40, 0);
        `CHECK({err, q}, 33'h1_0000_0000)
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_a000);
        @(negedge core_clk);
        `CHECK(tref, 1'b1)
        // Single conversion, no transfers: flag per result
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_5000);
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_000b);
        repeat (100) @(posedge core_clk);
        apb(0, adc_seq_pkg::RESULT_OFS, 0);
        `CHECK(q, 32'h0000_02a5)
        `CHECK(irq, 1'b1)
        global_irq_enable <= 1'b0;
        @(negedge core_clk);
        `CHECK(irq, 1'b0)
        @(posedge core_clk);
        global_irq_enable <= 1'b1;
        ack <= 1'b1;
        @(posedge core_clk);
        ack <= 1'b0;
        @(posedge core_clk);
        `CHECK(irq, 1'b0)
        // Two-block transfer of a four-channel sequence, n = 2
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0000);
        apb(1, adc_seq_pkg::XCTRL_OFS, 32'h0000_0004);
        apb(1, adc_seq_pkg::XCOUNT_OFS, 32'h0000_0002);
        apb(1, adc_seq_pkg::XSTART_OFS, 32'h0000_0300);
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_3001);
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0083);
        waitXfer(2);
        apb(0, adc_seq_pkg::XCTRL_OFS, 0);
        `CHECK(q[0], 1'b1)
        waitXfer(4);
        repeat (80) @(posedge core_clk);
        `CHECK(far.addrLog.size(), 4)
        for (int i = 0; i < 4; i++)
        begin
            `CHECK(far.addrLog[i], 16'h0300 + 16'(2 * i))
            `CHECK(far.dataLog[i], 16'h02a3 - 16'(i))
        end
        apb(0, adc_seq_pkg::XCTRL_OFS, 0);
        `CHECK(q[0], 1'b0)
        // Repeat single on the pin, no transfers, then stop
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0000);
        apb(1, adc_seq_pkg::XCOUNT_OFS, 32'h0000_0000);
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_1002);
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0082);
        trig <= 1'b1;
        repeat (90) @(posedge core_clk);
        `CHECK(chan, 4'h1)
        `CHECK(samp | conv, 1'b1)
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0080);
        repeat (40) @(posedge core_clk);
        `CHECK({samp, conv}, 2'b00)
        `CHECK(far.addrLog.size(), 4)
        // One transfer with the main clock stopped
        apb(1, adc_seq_pkg::XCOUNT_OFS, 32'h0000_0001);
        far.clkOff <= 1'b1;
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_0000);
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0003);
        repeat (100) @(posedge core_clk);
        `CHECK(mrun, 1'b1)
        `CHECK(far.addrLog.size(), 4)
        waitXfer(5);
        far.clkOff <= 1'b0;
        `CHECK(far.addrLog[4], 16'h0300)
        @(negedge core_clk);
        `CHECK(mrun, 1'b0)
        // Repeat sequence with continuous one-block transfers, n = 2
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0000);
        apb(1, adc_seq_pkg::XCTRL_OFS, 32'h0000_0002);
        apb(1, adc_seq_pkg::XCOUNT_OFS, 32'h0000_0002);
        apb(1, adc_seq_pkg::CTRL1_OFS, 32'h0000_1003);
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0083);
        waitXfer(9);
        `CHECK(far.addrLog[7], 16'h0300)
        `CHECK(far.dataLog[7], 16'h02a1)
        apb(1, adc_seq_pkg::CTRL0_OFS, 32'h0000_0080);
        repeat (60) @(posedge core_clk);
        `CHECK({samp, conv}, 2'b00)
        `CHECK(far.dataLog[far.dataLog.size() - 1], 16'h02a0)
        results();
    end
endmodule
